/* File: design/i2c_target_register_port.sv */
// Two-wire target register port with a write request FIFO
`timescale 1ns/1ps

module reg_write_fifo #(
  parameter int WIDTH = 23,
  parameter int DEPTH = 4
) (
  input wire logic core_clk, // System clock
  input wire logic nrst, // Async reset, active low
  input wire logic in_valid, // Word offered
  input wire logic [WIDTH-1:0] in_data, // Word in
  output logic in_ready, // Room for a word
  output logic out_valid, // Word available
  output logic [WIDTH-1:0] out_data, // Oldest word
  input wire logic out_ready // Drain side takes word
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
  logic [AW:0] cnt_r, cnt_nxt;
  logic push, pop;

  function automatic logic [AW-1:0] wrap_inc(input logic [AW-1:0] p);
    wrap_inc = (p == LAST) ? '0 : AW'(p + 1'b1);
  endfunction

  assign in_ready = (cnt_r != FULL);
  assign out_valid = (cnt_r != '0);
  assign out_data = mem_r[rd_r];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_comb begin
    wr_nxt = push ? wrap_inc(wr_r) : wr_r;
    rd_nxt = pop ? wrap_inc(rd_r) : rd_r;
    cnt_nxt = cnt_r;
    if (push && !pop) begin
      cnt_nxt = (AW + 1)'(cnt_r + 1'b1);
    end else if (pop && !push) begin
      cnt_nxt = (AW + 1)'(cnt_r - 1'b1);
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
    end else begin
      wr_r <= wr_nxt;
      rd_r <= rd_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // Storage needs no reset; count guards every read
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_r[wr_r] <= in_data;
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////

module i2c_target_register_port (
  input wire logic core_clk, // System clock, 40 MHz
  input wire logic nrst, // Async reset, active low
  input wire logic proto_sel_i2c, // Protocol select pin, high = two-wire
  input wire logic address_strap_low, // Address strap pin, low
  input wire logic address_strap_high, // Address strap pin, high
  input wire logic scl_i, // Bus clock level
  input wire logic sda_i, // Bus data level
  output logic sda_o, // Data drive value, always low
  output logic sda_oe_n, // Data enable, low while pulling
  output logic wr_valid, // Register write pending
  output i2c_target_pkg::reg_write_t wr_req, // Pointer and data
  input wire logic wr_ready, // Register file takes write
  output logic [6:0] read_addr, // Pointer to read
  input wire logic [15:0] read_data, // Register at read_addr
  output logic i2c_mode, // Two-wire mode chosen
  output logic busy // Transfer under way, from START until STOP, address miss or NACK
);
  import i2c_target_pkg::*;

  logic scl_meta_r, scl_sync_r, scl_prev_r;
  logic sda_meta_r, sda_sync_r, sda_prev_r;
  logic [1:0] strap_meta_r, strap_sync_r;
  logic sel_meta_r, sel_sync_r;
  logic scl_rise, scl_fall, start_cond, stop_cond;

  port_state_t state_r, state_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [7:0] shift_r, shift_nxt;
  logic [7:0] hi_r, hi_nxt;
  logic [15:0] rdata_r, rdata_nxt;
  logic [6:0] ptr_r, ptr_nxt;
  logic [1:0] strap_r, strap_nxt;
  logic [1:0] settle_r, settle_nxt;
  logic drive_r, drive_nxt, rw_r, rw_nxt, block_r, block_nxt;
  logic byte_hi_r, byte_hi_nxt, mode_r, mode_nxt, done_r, done_nxt;
  logic push_r, push_nxt;
  reg_write_t push_data_r, push_data_nxt;
  logic fifo_in_ready;
  logic [15:0] rd_val;

  function automatic logic [6:0] target_addr(input logic [1:0] s);
    target_addr = TARGET_BASE;
    target_addr[STRAP_LOW_POS] = s[0];
    target_addr[STRAP_HIGH_POS] = s[1];
  endfunction

  function automatic logic [6:0] next_ptr(input logic [6:0] p);
    next_ptr = (p == PTR_CEIL) ? p : 7'(p + 7'h01); // [RULE22]
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; first stage feeds only the second
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      scl_meta_r <= 1'b1;
      scl_sync_r <= 1'b1;
      scl_prev_r <= 1'b1;
      sda_meta_r <= 1'b1;
      sda_sync_r <= 1'b1;
      sda_prev_r <= 1'b1;
      strap_meta_r <= 2'h0;
      strap_sync_r <= 2'h0;
      sel_meta_r <= 1'b0;
      sel_sync_r <= 1'b0;
    end else begin
      scl_meta_r <= scl_i; // [RULE23]
      scl_sync_r <= scl_meta_r;
      scl_prev_r <= scl_sync_r;
      sda_meta_r <= sda_i;
      sda_sync_r <= sda_meta_r;
      sda_prev_r <= sda_sync_r;
      strap_meta_r <= {address_strap_high, address_strap_low};
      strap_sync_r <= strap_meta_r;
      sel_meta_r <= proto_sel_i2c;
      sel_sync_r <= sel_meta_r;
    end
  end

  assign scl_rise = scl_sync_r & ~scl_prev_r; // [RULE23]
  assign scl_fall = ~scl_sync_r & scl_prev_r;
  // SDA moving under a steady high SCL is a condition, never data
  assign start_cond = scl_sync_r & scl_prev_r & sda_prev_r
    & ~sda_sync_r; // [RULE10] [RULE6]
  assign stop_cond = scl_sync_r & scl_prev_r & ~sda_prev_r
    & sda_sync_r; // [RULE7]

  // Out-of-map pointers read as zero
  assign rd_val = (ptr_r <= REG_LAST) ? read_data : 16'h0000; // [RULE2]

  ////////////////////////////////////////////////////////////////////////
  // Bus sequencer; all bit timing follows sampled SCL edges, so any
  // fast or fast-plus clock well below core_clk / 6 is followed
  always_comb begin // [RULE5]
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    shift_nxt = shift_r;
    hi_nxt = hi_r;
    rdata_nxt = rdata_r;
    ptr_nxt = ptr_r;
    strap_nxt = strap_r;
    settle_nxt = settle_r;
    drive_nxt = drive_r;
    rw_nxt = rw_r;
    block_nxt = block_r;
    byte_hi_nxt = byte_hi_r;
    mode_nxt = mode_r;
    done_nxt = done_r;
    push_nxt = 1'b0;
    push_data_nxt = push_data_r;
    if (!done_r) begin
      // Protocol fixed once, after the select pin has settled
      settle_nxt = 2'(settle_r + 2'h1);
      if (settle_r == MODE_SETTLE) begin
        done_nxt = 1'b1; // [RULE1]
        mode_nxt = sel_sync_r;
      end
    end else if (!mode_r) begin
      state_nxt = ST_IDLE; // [RULE1]
      drive_nxt = 1'b0;
    end else if (start_cond) begin
      // Repeated START restarts framing, dropping any partial byte
      state_nxt = ST_ADDR; // [RULE15] [RULE18]
      cnt_nxt = 4'h0;
      drive_nxt = 1'b0;
      strap_nxt = strap_sync_r; // [RULE19]
    end else if (stop_cond) begin
      state_nxt = ST_IDLE; // [RULE7] [RULE18] [RULE16]
      drive_nxt = 1'b0;
    end else begin
      unique case (state_r)
        ST_IDLE, ST_IGNORE: begin
          drive_nxt = 1'b0; // [RULE16]
        end
        ST_ADDR, ST_PTR, ST_WDATA: begin
          if (scl_rise) begin
            shift_nxt = {shift_r[6:0], sda_sync_r}; // [RULE4]
            cnt_nxt = 4'(cnt_r + 4'h1);
          end
          if (scl_fall && cnt_r == BITS_PER_BYTE) begin // [RULE9]
            state_nxt = ST_IGNORE;
            if (state_r == ST_ADDR) begin
              if (shift_r[7:1] == target_addr(strap_r)) begin
                drive_nxt = 1'b1; // [RULE8]
                rw_nxt = shift_r[0]; // [RULE13]
                state_nxt = ST_ADDR_ACK;
              end
            end else if (state_r == ST_PTR) begin
              block_nxt = shift_r[7]; // [RULE17] [RULE20]
              ptr_nxt = shift_r[6:0]; // [RULE21]
              drive_nxt = 1'b1; // [RULE14]
              state_nxt = ST_PTR_ACK;
            end else if (byte_hi_r) begin
              hi_nxt = shift_r; // [RULE20]
              drive_nxt = 1'b1;
              state_nxt = ST_WDATA_ACK;
            end else if (fifo_in_ready && !push_r) begin
              // Full queue refuses the word with a NACK
              push_nxt = (ptr_r <= REG_LAST); // [RULE2]
              push_data_nxt = '{ptr: ptr_r, data: {hi_r, shift_r}};
              drive_nxt = 1'b1; // [RULE14]
              state_nxt = ST_WDATA_ACK;
            end
          end
        end
        ST_ADDR_ACK, ST_PTR_ACK, ST_WDATA_ACK: begin
          // Held from one fall to the next covers the whole high phase
          if (scl_fall) begin // [RULE11]
            drive_nxt = 1'b0;
            cnt_nxt = 4'h0;
            byte_hi_nxt = 1'b1;
            if (state_r == ST_ADDR_ACK && rw_r) begin
              rdata_nxt = rd_val; // [RULE21]
              shift_nxt = rd_val[15:8];
              drive_nxt = ~rd_val[15];
              state_nxt = ST_RDATA; // [RULE13]
            end else if (state_r == ST_ADDR_ACK) begin
              state_nxt = ST_PTR;
            end else if (state_r == ST_PTR_ACK) begin
              state_nxt = ST_WDATA;
            end else begin
              state_nxt = ST_WDATA;
              byte_hi_nxt = ~byte_hi_r;
              if (!byte_hi_r && block_r) begin
                ptr_nxt = next_ptr(ptr_r); // [RULE22]
              end
            end
          end
        end
        ST_RDATA: begin
          if (scl_rise) begin
            cnt_nxt = 4'(cnt_r + 4'h1);
          end
          if (scl_fall) begin
            if (cnt_r == BITS_PER_BYTE) begin
              drive_nxt = 1'b0; // [RULE9]
              state_nxt = ST_RACK;
            end else begin
              shift_nxt = {shift_r[6:0], 1'b0}; // [RULE4]
              drive_nxt = ~shift_r[6];
            end
          end
        end
        ST_RACK: begin
          if (scl_rise && sda_sync_r) begin
            state_nxt = ST_IGNORE; // [RULE12]
          end else if (scl_fall) begin
            cnt_nxt = 4'h0;
            state_nxt = ST_RDATA;
            if (byte_hi_r) begin
              shift_nxt = rdata_r[7:0];
              drive_nxt = ~rdata_r[7];
              byte_hi_nxt = 1'b0;
              if (block_r) begin
                ptr_nxt = next_ptr(ptr_r); // [RULE22]
              end
            end else begin
              rdata_nxt = rd_val;
              shift_nxt = rd_val[15:8];
              drive_nxt = ~rd_val[15];
              byte_hi_nxt = 1'b1;
            end
          end
        end
        default: begin
          state_nxt = ST_IDLE;
          drive_nxt = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= ST_IDLE; // [RULE23]
      cnt_r <= 4'h0;
      shift_r <= 8'h00;
      hi_r <= 8'h00;
      rdata_r <= 16'h0000;
      ptr_r <= PTR_RESET;
      strap_r <= 2'h0;
      settle_r <= 2'h0;
      drive_r <= 1'b0;
      rw_r <= 1'b0;
      block_r <= 1'b0;
      byte_hi_r <= 1'b1;
      mode_r <= 1'b0;
      done_r <= 1'b0;
      push_r <= 1'b0;
      push_data_r <= '0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      shift_r <= shift_nxt;
      hi_r <= hi_nxt;
      rdata_r <= rdata_nxt;
      ptr_r <= ptr_nxt;
      strap_r <= strap_nxt;
      settle_r <= settle_nxt;
      drive_r <= drive_nxt;
      rw_r <= rw_nxt;
      block_r <= block_nxt;
      byte_hi_r <= byte_hi_nxt;
      mode_r <= mode_nxt;
      done_r <= done_nxt;
      push_r <= push_nxt;
      push_data_r <= push_data_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  reg_write_fifo #(
    .WIDTH($bits(reg_write_t)),
    .DEPTH(WR_FIFO_DEPTH)
  ) u_wr_fifo (
    .core_clk(core_clk),
    .nrst(nrst),
    .in_valid(push_r),
    .in_data(push_data_r),
    .in_ready(fifo_in_ready),
    .out_valid(wr_valid),
    .out_data(wr_req),
    .out_ready(wr_ready)
  );

  // Only SDA is ever pulled; SCL has no output at all
  assign sda_o = 1'b0; // [RULE3]
  assign sda_oe_n = ~drive_r;
  assign read_addr = ptr_r;
  assign i2c_mode = mode_r;
  assign busy = (state_r != ST_IDLE) && (state_r != ST_IGNORE);
endmodule

/* File: include/i2c_target_pkg.sv */
// Constants, types and carriers for the two-wire target register port
// Behaviour
// RULE1 - Protocol chosen once after reset from a select pin, never changed
// RULE2 - Register map spans pointer values 0x00 through 0x32 inclusive
// RULE3 - Port is target only; it never drives SCL nor makes START/STOP
// RULE4 - All bytes shift most significant bit first, both directions
// RULE5 - Bus supports fast mode and fast mode plus timing
// RULE6 - Controller opens transactions with SDA falling while SCL high
// RULE7 - STOP is SDA rising while SCL high; it ends and resets bus state
// RULE8 - Matching address byte acknowledged on ninth pulse; last bit direction
// RULE9 - Data bytes take eight pulses, then receiver drives one acknowledge bit
// RULE10 - SDA stable while SCL high; changes then are bus conditions
// RULE11 - Acknowledge held low through whole high phase of ninth pulse
// RULE12 - Controller NACK ends a read; device stops sending, releases SDA
// RULE13 - Direction bit high means target sends; low means controller sends
// RULE14 - Byte count unbounded; receiver acknowledges each accepted byte
// RULE15 - Repeated START behaves exactly like START
// RULE16 - Bus idle when SDA and SCL high; device leaves SDA released
// RULE17 - Block flag high makes transfer walk successive registers
// RULE18 - Only START or STOP ends a transaction; partial bytes dropped
// RULE19 - Address straps sampled at every START select one of four addresses
// RULE20 - Write: flag plus seven-bit pointer byte, then data upper byte first
// RULE21 - Reads use the last written pointer; it persists until rewritten
// RULE22 - Block pointer advances per register, saturating at 0x7f
// RULE23 - SDA and SCL synchronised; conditions and edges found from samples
package i2c_target_pkg;

  localparam logic [6:0] REG_LAST = 7'h32;
  localparam logic [6:0] PTR_CEIL = 7'h7f;
  localparam logic [6:0] PTR_RESET = 7'h00;
  localparam logic [6:0] TARGET_BASE = 7'h50;
  localparam int STRAP_LOW_POS = 0;
  localparam int STRAP_HIGH_POS = 2;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [1:0] MODE_SETTLE = 2'h3;
  localparam int WR_FIFO_DEPTH = 4;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_ADDR = 4'h1,
    ST_ADDR_ACK = 4'h2,
    ST_PTR = 4'h3,
    ST_PTR_ACK = 4'h4,
    ST_WDATA = 4'h5,
    ST_WDATA_ACK = 4'h6,
    ST_RDATA = 4'h7,
    ST_RACK = 4'h8,
    ST_IGNORE = 4'h9
  } port_state_t;

  typedef struct packed {
    logic [6:0] ptr;
    logic [15:0] data;
  } reg_write_t;

endpackage

/* File: sim/i2c_ctl_model.sv */
// Behavioural two-wire bus controller
`timescale 1ns/1ps
module i2c_ctl_model (
  input wire logic core_clk, // Pacing clock
  input wire logic sda, // Resolved data line
  output logic scl, // Bus clock, high between frames
  output logic sda_low // Pulls data line low
);
  initial begin
    scl = 1'h1;
    sda_low = 1'h0;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  // Also serves as repeated start when the clock is low
  task automatic start();
    tick(1);
    sda_low = 1'h0;
    tick(3);
    scl = 1'h1;
    tick(4);
    sda_low = 1'h1;
    tick(4);
    scl = 1'h0;
  endtask
  task automatic stop();
    tick(1);
    sda_low = 1'h1;
    tick(3);
    scl = 1'h1;
    tick(4);
    sda_low = 1'h0;
    tick(4);
  endtask
  // Data set only while the clock is low
  task automatic bit_io(input logic b, output logic r);
    tick(1);
    sda_low = !b;
    tick(3);
    scl = 1'h1;
    tick(4);
    r = sda;
    scl = 1'h0;
  endtask
  task automatic xfer(input logic [7:0] tx, input logic ack_in,
      output logic [7:0] rx, output logic ack_seen);
    for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
    bit_io(ack_in, ack_seen);
  endtask
endmodule

/* File: sim/i2c_port_checker.sv */
// Port assertions for the two-wire target register port
`timescale 1ns/1ps
module i2c_port_checker (
  input wire logic core_clk, // Clock
  input wire logic nrst, // Reset, active low
  input wire logic proto_sel_i2c, // Mode pin
  input wire logic address_strap_low, // Strap
  input wire logic address_strap_high, // Strap
  input wire logic scl_i, // Bus clock
  input wire logic sda_i, // Bus data
  input wire logic sda_o, // Drive value
  input wire logic sda_oe_n, // Low pulls
  input wire logic wr_valid, // Write pending
  input wire i2c_target_pkg::reg_write_t wr_req, // Write word
  input wire logic wr_ready, // Write taken
  input wire logic [6:0] read_addr, // Pointer
  input wire logic [15:0] read_data, // Read value
  input wire logic i2c_mode, // Mode chosen
  input wire logic busy // Transfer on
);
  import i2c_target_pkg::*;
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////
  property p_off_mode;
    !i2c_mode |-> sda_oe_n;
  endproperty
  a_off_mode: assert property (p_off_mode)
    else $error("drive outside mode");
  property p_mode_kept;
    i2c_mode |=> i2c_mode;
  endproperty
  a_mode_kept: assert property (p_mode_kept)
    else $error("mode dropped");
  property p_take_low;
    $fell(sda_oe_n) |-> !scl_i;
  endproperty
  a_take_low: assert property (p_take_low)
    else $error("drive began with clock high");
  property p_let_go_low;
    $rose(sda_oe_n) |-> !scl_i;
  endproperty
  a_let_go_low: assert property (p_let_go_low)
    else $error("drive ended with clock high");
  // Bus end releases the line and the transfer within six cycles
  property p_stop_ends;
    scl_i && $past(scl_i) && sda_i && !$past(sda_i)
      |-> ##[1:6] (sda_oe_n && !busy);
  endproperty
  a_stop_ends: assert property (p_stop_ends)
    else $error("stop not honoured");
  property p_fifo_hold;
    wr_valid && !wr_ready |=> wr_valid && $stable(wr_req);
  endproperty
  a_fifo_hold: assert property (p_fifo_hold)
    else $error("queued write lost");
  property p_in_map;
    wr_valid |-> wr_req.ptr <= REG_LAST;
  endproperty
  a_in_map: assert property (p_in_map)
    else $error("write outside map");
  property p_ptr_kept;
    !busy && !$past(busy) |-> $stable(read_addr);
  endproperty
  a_ptr_kept: assert property (p_ptr_kept)
    else $error("pointer moved while idle");
endmodule

bind i2c_target_register_port i2c_port_checker u_chk (.*);

/* File: sim/tb_i2c_target_register_port.sv */
// Self-checking bench for the two-wire target register port
`timescale 1ns/1ps
module tb_i2c_target_register_port;
  import i2c_target_pkg::*;
  typedef struct packed {
    logic sh;
    logic sl;
    logic [6:0] p;
    logic [15:0] d;
  } row_t;
  logic core_clk;
  logic nrst = 1'h0;
  logic proto_sel_i2c = 1'h1;
  logic address_strap_low = 1'h0;
  logic address_strap_high = 1'h0;
  logic wr_ready = 1'h1;
  logic sda_o, sda_oe_n, wr_valid, i2c_mode, busy, scl, sda_low, sda;
  reg_write_t wr_req;
  logic [6:0] read_addr;
  logic [15:0] read_data;
  logic [15:0] regs [0:127];
  logic [15:0] rd_buf [0:7];
  reg_write_t exp_q [$];
  int bad_count = 0;
  int checks_done = 0;
  int cycles = 0;
  row_t rows [4] = '{'{1'h0, 1'h0, 7'h00, 16'h1234},
    '{1'h0, 1'h1, 7'h05, 16'h8001}, '{1'h1, 1'h0, 7'h32, 16'hfffe},
    '{1'h1, 1'h1, 7'h33, 16'h5a5a}};
  // Open drain with pull-up: low when either side pulls
  assign sda = !(sda_low || !sda_oe_n);
  assign read_data = regs[read_addr];
  i2c_target_register_port DUT (.core_clk(core_clk), .nrst(nrst),
    .proto_sel_i2c(proto_sel_i2c), .address_strap_low(address_strap_low),
    .address_strap_high(address_strap_high), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe_n(sda_oe_n), .wr_valid(wr_valid),
    .wr_req(wr_req), .wr_ready(wr_ready), .read_addr(read_addr),
    .read_data(read_data), .i2c_mode(i2c_mode), .busy(busy));
  i2c_ctl_model ctl (.core_clk(core_clk), .sda(sda), .scl(scl),
    .sda_low(sda_low));
  ////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'h0;
    forever #12.5 core_clk = !core_clk;
  end
  initial foreach (regs[i]) regs[i] = 16'h0;
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      bad_count++;
      close_out();
    end
  end
  // Register file side of the queue
  always @(posedge core_clk) if (wr_valid && wr_ready) begin
    if (exp_q.size() == 0) check("wr_extra", 1, 0);
    else check("wr_req", wr_req, exp_q.pop_front());
    regs[wr_req.ptr] <= wr_req.data;
  end
  task automatic check(input string nm, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic do_reset(input logic sel);
    @(negedge core_clk);
    nrst = 1'h0;
    proto_sel_i2c = sel;
    repeat (12) @(negedge core_clk);
    check("oe_rst", sda_oe_n, 1);
    check("ptr_rst", read_addr, 0);
    check("sda_o", sda_o, 0);
    check("busy_rst", busy, 0);
    nrst = 1'h1;
    repeat (12) @(negedge core_clk);
    check("mode", i2c_mode, sel);
  endtask
  task automatic expect_words(input logic [6:0] p, input logic blk,
      input logic [15:0] d, input int n);
    for (int k = 0; k < n; k++) begin
      if (p <= REG_LAST) exp_q.push_back('{p, d + 16'(k)});
      if (blk && p != PTR_CEIL) p++;
    end
  endtask
  // Words d, d+1 ... upper byte first; acks counts bytes taken
  task automatic wr(input logic [6:0] a, input logic blk,
      input logic [6:0] p, input logic [15:0] d, input int n,
      input logic end_stop, output int acks);
    logic [7:0] rx;
    logic nak;
    logic [15:0] w;
    logic [7:0] seq [$];
    seq.push_back({a, 1'h0});
    seq.push_back({blk, p});
    for (int k = 0; k < n; k++) begin
      w = d + 16'(k);
      seq.push_back(w[15:8]);
      seq.push_back(w[7:0]);
    end
    acks = 0;
    ctl.start();
    foreach (seq[i]) begin
      ctl.xfer(seq[i], 1'h1, rx, nak);
      if (nak) break;
      acks++;
    end
    if (end_stop) ctl.stop();
  endtask
  task automatic rd(input logic [6:0] a, input int n, output logic ak);
    logic [7:0] hi;
    logic [7:0] lo;
    logic x;
    ctl.start();
    ctl.xfer({a, 1'h1}, 1'h1, hi, ak);
    for (int k = 0; k < n; k++) begin
      ctl.xfer(8'hff, 1'h0, hi, x);
      ctl.xfer(8'hff, k == n - 1, lo, x);
      rd_buf[k] = {hi, lo};
    end
    repeat (5) @(negedge core_clk);
    check("release", sda_oe_n, 1);
    check("rd_busy", busy, 0);
    ctl.stop();
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    int acks;
    logic ak;
    logic [6:0] a;
    do_reset(1'h1);
    foreach (rows[i]) begin
      address_strap_high = rows[i].sh;
      address_strap_low = rows[i].sl;
      a = TARGET_BASE | 7'({rows[i].sh, 1'h0, rows[i].sl});
      expect_words(rows[i].p, 1'h0, rows[i].d, 1);
      wr(a, 1'h0, rows[i].p, rows[i].d, 1, 1'h1, acks);
      check("wr_acks", acks, 4);
      check("ptr", read_addr, rows[i].p);
      rd(a, 1, ak);
      check("rd_ack", ak, 0);
      check("rd", rd_buf[0], rows[i].p <= REG_LAST ? rows[i].d : 0);
    end
    wr(7'h50, 1'h0, 7'h00, 16'h0, 1, 1'h1, acks);
    check("miss", acks, 0);
    // Torn byte then a clean block write
    ctl.start();
    repeat (3) ctl.bit_io(1'h1, ak);
    ctl.stop();
    expect_words(7'h10, 1'h1, 16'hc000, 3);
    wr(7'h55, 1'h1, 7'h10, 16'hc000, 3, 1'h1, acks);
    check("blk_acks", acks, 8);
    wr(7'h55, 1'h1, 7'h10, 16'h0, 0, 1'h0, acks);
    rd(7'h55, 3, ak);
    for (int k = 0; k < 3; k++) begin
      check("blk_rd", rd_buf[k], 16'hc000 + 16'(k));
    end
    wr(7'h55, 1'h1, 7'h7e, 16'h0, 2, 1'h1, acks);
    check("sat", read_addr, PTR_CEIL);
    wr_ready = 1'h0;
    expect_words(7'h20, 1'h1, 16'h0100, 4);
    wr(7'h55, 1'h1, 7'h20, 16'h0100, 5, 1'h1, acks);
    check("full_acks", acks, 11);
    wr_ready = 1'h1;
    repeat (8) @(negedge core_clk);
    check("drained", exp_q.size(), 0);
    do_reset(1'h0);
    proto_sel_i2c = 1'h1;
    wr(7'h55, 1'h0, 7'h01, 16'h0, 1, 1'h1, acks);
    check("off", acks, 0);
    close_out();
  end
endmodule
